// >>> core/cpod_core.sv
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - Fetch one to three consecutive instruction bytes
// - Multi-byte operands low byte at lowest address
// - Direct address: byte two low, three high
// - Indirect address: first register high, second low
// - Immediate operand from instruction, low byte first
// - Program counter advances to increasing addresses
// - Direct branch loads counter from bytes two/three
// - Indirect branch loads counter from register pair
// - Restart call jumps to eight times field
// - Five one-bit flags, set one, reset zero
// - Zero flag set when result is zero
// - Sign flag copies result most significant bit
// - Parity flag set on even ones count
// - Carry flag on carry or borrow out
// - Half carry on carry from bit three
// - Half carry updated by single-precision arithmetic, logic
// - Three-bit destination and source register fields
// - Two-bit pair field selects pair or stack
// - Counter and stack pointer sixteen bits, each read and written whole
// - Data words eight bits, bit seven most significant
// - Address and control drivers float for external master
// - Subtraction two's complement, carry marks borrow
module cpod_core
  import cpod_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Memory bus
  output logic      [15:0] mem_addr_o,
  output logic             mem_addr_oe_o,
  output logic             mem_rd_o,
  output logic             mem_wr_o,
  output logic             mem_ctl_oe_o,
  output logic      [7:0]  mem_wdata_o,
  output logic             mem_wdata_oe_o,
  input  wire logic [7:0]  mem_rdata_i,
  // External master hand-over
  input  wire logic        dma_hold_i,
  output logic             dma_grant_o
);

  // Whole state of the block
  typedef struct packed {
    cpod_state_t      st;      // Memory sequencer state
    logic             go;      // Command waiting to start
    cpod_cmd_t        cmd;     // Current command
    logic [1:0]       len;     // Fetch length field
    logic [1:0]       idx;     // Byte index of memory access
    logic [1:0]       last;    // Last byte index
    logic [7:0][7:0]  gpr;     // General registers by field code
    logic [15:0]      pc;      // Program counter
    logic [15:0]      sp;      // Stack pointer
    logic [15:0]      ea;      // Last effective base address
    logic [FLG_W-1:0] flg;     // Condition flags
    logic [7:0]       b1;      // Instruction byte one
    logic [7:0]       b2;      // Instruction byte two
    logic [7:0]       b3;      // Instruction byte three
    logic [15:0]      maddr;   // Memory address pins
    logic [7:0]       mwdata;  // Memory write data pins
    logic             mrd;     // Read strobe
    logic             mwr;     // Write strobe
    logic             moe;     // Address and control drive enable
    logic             grant;   // Buses handed over
    logic             aw_pend; // Write data phase due
    logic             ar_pend; // Read data phase due
    logic             aok;     // Captured access is mapped
    logic [DEC_W-1:0] aaddr;   // Captured register offset
    logic [31:0]      hrdata;  // Read data
    logic             hready;  // Ready out
    logic             hresp;   // Response, always OKAY
  } cpod_regs_t;

  cpod_regs_t r;   // Registered state
  cpod_regs_t n;   // Next state

  // Register pair value, first register high
  function automatic logic [15:0] pair_val(input cpod_regs_t s,
                                           input logic [1:0] p);
    logic [15:0] v;
    v = s.sp;
    case (p)
      PAIR_BC: v = {s.gpr[REG_B], s.gpr[REG_C]};
      PAIR_DE: v = {s.gpr[REG_D], s.gpr[REG_E]};
      PAIR_HL: v = {s.gpr[REG_H], s.gpr[REG_L]};
      default: v = s.sp;
    endcase
    return v;
  endfunction

  // Register read multiplexer, unmapped reads as zero
  function automatic logic [31:0] rd_mux(input cpod_regs_t s,
                                         input logic [DEC_W-1:0] a,
                                         input logic ok,
                                         input logic busy);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (ok) begin
      case (a)
        OFS_CTRL:  v = {30'h0, s.grant, busy};
        OFS_INSTR: v = {8'h00, s.b3, s.b2, s.b1};
        OFS_FLAGS: v = {27'h0, s.flg};
        OFS_PC:    v = {16'h0, s.pc};
        OFS_SP:    v = {16'h0, s.sp};
        OFS_GPR0:  v = {s.gpr[REG_D], s.gpr[REG_C], s.gpr[REG_B],
                        s.gpr[REG_A]};
        OFS_GPR1:  v = {8'h00, s.gpr[REG_L], s.gpr[REG_H], s.gpr[REG_E]};
        OFS_EADDR: v = {16'h0, s.ea};
        default:   v = 32'h0000_0000;
      endcase
    end
    return v;
  endfunction

  // Next-state logic: bus slave, command engine, memory sequencer
  always_comb begin
    logic        busy;
    logic [2:0]  dst;
    logic [2:0]  src;
    logic [1:0]  prs;
    logic [2:0]  aop;
    logic [7:0]  acc;
    logic [7:0]  opnd;
    logic [7:0]  res;
    logic [8:0]  sum;
    logic [4:0]  half;
    logic        cin;
    logic        setf;
    busy = 1'b0;
    dst  = 3'h0;
    src  = 3'h0;
    prs  = 2'h0;
    aop  = 3'h0;
    acc  = 8'h00;
    opnd = 8'h00;
    res  = 8'h00;
    sum  = 9'h000;
    half = 5'h00;
    cin  = 1'b0;
    setf = 1'b0;
    n    = r;

    busy = r.go || (r.st != ST_IDLE);
    dst  = r.b1[FLD_DST_LSB +: 3];
    src  = r.b1[FLD_SRC_LSB +: 3];
    prs  = r.b1[FLD_PAIR_LSB +: 2];
    aop  = r.b1[FLD_ALU_LSB +: 3];
    acc  = r.gpr[REG_A];

    // Read data phase: one wait state, so a write just before is seen
    n.hready = 1'b1;
    n.hresp  = HRESP_OK;
    n.ar_pend = 1'b0;
    n.aw_pend = 1'b0;
    if (r.ar_pend) begin
      n.hrdata = rd_mux(r, r.aaddr, r.aok, busy);
    end

    // Address phase capture
    if (hsel_i && hready_i && htrans_i[1]) begin
      n.aaddr = haddr_i[DEC_W-1:0];
      n.aok   = (haddr_i[31:DEC_W] == '0) && (hsize_i == SIZE_WORD);
      if (hwrite_i) begin
        n.aw_pend = 1'b1;
      end else begin
        n.ar_pend = 1'b1;
        n.hready  = 1'b0;
      end
    end

    // Write data phase; state is frozen while a command runs
    if (r.aw_pend && r.aok && !busy) begin
      case (r.aaddr)
        OFS_CTRL: begin
          n.cmd = cpod_cmd_t'(hwdata_i[CTRL_CMD_LSB +: 4]);
          n.len = hwdata_i[CTRL_LEN_LSB +: 2];
          n.go  = 1'b1;
        end
        OFS_INSTR: begin
          n.b1 = hwdata_i[7:0];
          n.b2 = hwdata_i[15:8];
          n.b3 = hwdata_i[23:16];
        end
        OFS_FLAGS: n.flg = hwdata_i[FLG_W-1:0];
        OFS_PC:    n.pc = hwdata_i[15:0];
        OFS_SP:    n.sp = hwdata_i[15:0];
        OFS_GPR0:  n.gpr[3:0] = hwdata_i;
        OFS_GPR1:  n.gpr[6:4] = hwdata_i[23:0];
        default:   n.aok = r.aok;
      endcase
    end

    // Command engine and memory sequencer
    case (r.st)
      ST_IDLE: begin
        if (r.go) begin
          n.go   = 1'b0;
          n.idx  = 2'h0;
          n.last = 2'h0;
          case (r.cmd)
            CMD_FETCH: begin
              n.ea   = r.pc;
              n.last = (r.len == 2'h0) ? 2'h0 : r.len - 2'h1;
              n.st   = ST_ISSUE;
            end
            CMD_MOV: begin
              if (dst != REG_NONE) begin
                n.gpr[dst] = r.gpr[src];
              end
            end
            CMD_MVI: begin
              if (dst != REG_NONE) begin
                n.gpr[dst] = r.b2;
              end
            end
            CMD_LXI: begin
              case (prs)
                PAIR_BC: n.gpr[REG_B +: 2] = {r.b2, r.b3};
                PAIR_DE: n.gpr[REG_D +: 2] = {r.b2, r.b3};
                PAIR_HL: n.gpr[REG_H +: 2] = {r.b2, r.b3};
                default: n.sp = {r.b3, r.b2};
              endcase
            end
            CMD_ALUR, CMD_ALUI: begin
              opnd = (r.cmd == CMD_ALUR) ? r.gpr[src] : r.b2;
              setf = 1'b1;
              case (aop)
                ALU_ADD, ALU_ADC: begin
                  cin  = (aop == ALU_ADC) && r.flg[FLG_CARRY];
                  sum  = {1'b0, acc} + {1'b0, opnd} + {8'h00, cin};
                  half = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]}
                       + {4'h0, cin};
                  n.flg[FLG_CARRY] = sum[8];
                end
                ALU_AND: begin
                  sum  = {1'b0, acc & opnd};
                  half = {acc[3] | opnd[3], 4'h0};
                  n.flg[FLG_CARRY] = 1'b0;
                end
                ALU_XOR: begin
                  sum = {1'b0, acc ^ opnd};
                  n.flg[FLG_CARRY] = 1'b0;
                end
                ALU_OR: begin
                  sum = {1'b0, acc | opnd};
                  n.flg[FLG_CARRY] = 1'b0;
                end
                default: begin
                  // add the complement, carry means borrow
                  cin  = !((aop == ALU_SBB) && r.flg[FLG_CARRY]);
                  sum  = {1'b0, acc} + {1'b0, ~opnd} + {8'h00, cin};
                  half = {1'b0, acc[3:0]} + {1'b0, ~opnd[3:0]}
                       + {4'h0, cin};
                  n.flg[FLG_CARRY] = ~sum[8];
                end
              endcase
              res = sum[7:0];
              if (aop != ALU_CMP) begin
                n.gpr[REG_A] = res;
              end
            end
            CMD_INR, CMD_DCR: begin
              // Carry is left alone by increment and decrement
              opnd = (dst == REG_NONE) ? 8'h00 : r.gpr[dst];
              if (r.cmd == CMD_INR) begin
                sum  = {1'b0, opnd} + 9'h001;
                half = {1'b0, opnd[3:0]} + 5'h01;
              end else begin
                sum  = {1'b0, opnd} + 9'h0ff;
                half = {1'b0, opnd[3:0]} + 5'h0f;
              end
              res  = sum[7:0];
              setf = 1'b1;
              if (dst != REG_NONE) begin
                n.gpr[dst] = res;
              end
            end
            CMD_JMP: n.pc = {r.b3, r.b2};
            CMD_JPR: n.pc = pair_val(r, prs);
            CMD_RST: begin
              n.pc = 16'(r.b1[FLD_RST_LSB +: 3]) << RST_SHIFT;
            end
            CMD_LDA, CMD_STA, CMD_LD16: begin
              // byte two low, byte three high
              n.ea   = {r.b3, r.b2};
              n.last = (r.cmd == CMD_LD16) ? 2'h1 : 2'h0;
              n.st   = ST_ISSUE;
            end
            CMD_LDAX: begin
              n.ea = pair_val(r, prs);
              n.st = ST_ISSUE;
            end
            default: n.go = 1'b0;
          endcase
        end
      end
      ST_ISSUE: begin
        // Wait while the external master holds the buses
        if (!dma_hold_i) begin
          n.maddr  = r.ea + 16'(r.idx);
          n.mwdata = acc;
          n.mrd    = (r.cmd != CMD_STA);
          n.mwr    = (r.cmd == CMD_STA);
          n.st     = ST_STROBE;
        end
      end
      ST_STROBE: begin
        // Strobe stands one cycle; memory answers the cycle after
        n.mrd = 1'b0;
        n.mwr = 1'b0;
        n.st  = r.mwr ? ST_IDLE : ST_CAPT;
      end
      ST_CAPT: begin
        case (r.cmd)
          CMD_FETCH: begin
            case (r.idx)
              2'h0:    n.b1 = mem_rdata_i;
              2'h1:    n.b2 = mem_rdata_i;
              default: n.b3 = mem_rdata_i;
            endcase
            // counter steps past each fetched byte
            n.pc = r.pc + 16'h0001;
          end
          CMD_LD16: begin
            // low byte to second register first
            if (r.idx == 2'h0) begin
              n.gpr[REG_L] = mem_rdata_i;
            end else begin
              n.gpr[REG_H] = mem_rdata_i;
            end
          end
          default: n.gpr[REG_A] = mem_rdata_i;
        endcase
        if (r.idx == r.last) begin
          n.st = ST_IDLE;
        end else begin
          n.idx = r.idx + 2'h1;
          n.st  = ST_ISSUE;
        end
      end
      default: n.st = ST_IDLE;
    endcase

    // Shared zero, sign, parity and half-carry update
    if (setf) begin
      // flags forced to one or zero
      n.flg[FLG_ZERO]   = (res == 8'h00);
      // bit seven is the top bit
      n.flg[FLG_SIGN]   = res[7];
      n.flg[FLG_PARITY] = ~^res;
      // half carry on every flag-setting op
      n.flg[FLG_HALF]   = half[4];
    end

    // release address and control drivers on hold
    n.grant = dma_hold_i && (n.st != ST_STROBE);
    n.moe   = !n.grant;
  end

  // State register
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      r        <= '0;
      r.pc     <= PC_RST;
      r.sp     <= SP_RST;
      r.hready <= 1'b1;
      r.moe    <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // Outputs come straight from the state register
  assign hrdata_o       = r.hrdata;
  assign hreadyout_o    = r.hready;
  assign hresp_o        = r.hresp;
  assign mem_addr_o     = r.maddr;
  assign mem_addr_oe_o  = r.moe;
  assign mem_rd_o       = r.mrd;
  assign mem_wr_o       = r.mwr;
  assign mem_ctl_oe_o   = r.moe;
  assign mem_wdata_o    = r.mwdata;
  assign mem_wdata_oe_o = r.mwr;
  assign dma_grant_o    = r.grant;

endmodule

`default_nettype wire

// >>> pkg/cpod_pkg.sv
`default_nettype none
package cpod_pkg;

  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_INSTR = 8'h04;
  localparam logic [7:0] OFS_FLAGS = 8'h08;
  localparam logic [7:0] OFS_PC    = 8'h0c;
  localparam logic [7:0] OFS_SP    = 8'h10;
  localparam logic [7:0] OFS_GPR0  = 8'h14;
  localparam logic [7:0] OFS_GPR1  = 8'h18;
  localparam logic [7:0] OFS_EADDR = 8'h1c;

  // Bus decode widths and codes
  localparam int         DEC_W     = 8;
  localparam logic [2:0] SIZE_WORD = 3'h2;
  localparam logic       HRESP_OK  = 1'b0;

  // Control register fields
  localparam int CTRL_CMD_LSB = 0;
  localparam int CTRL_LEN_LSB = 4;
  localparam int STAT_BUSY    = 0;
  localparam int STAT_GRANT   = 1;

  // Flag bit positions inside the five-bit flag word
  localparam int FLG_CARRY  = 0;
  localparam int FLG_PARITY = 1;
  localparam int FLG_HALF   = 2;
  localparam int FLG_ZERO   = 3;
  localparam int FLG_SIGN   = 4;
  localparam int FLG_W      = 5;

  // Fields of the first instruction byte
  localparam int FLD_DST_LSB  = 3;
  localparam int FLD_SRC_LSB  = 0;
  localparam int FLD_PAIR_LSB = 4;
  localparam int FLD_RST_LSB  = 3;
  localparam int FLD_ALU_LSB  = 3;
  localparam int RST_SHIFT    = 3;

  // General register codes, in field order
  localparam logic [2:0] REG_A    = 3'h0;
  localparam logic [2:0] REG_B    = 3'h1;
  localparam logic [2:0] REG_C    = 3'h2;
  localparam logic [2:0] REG_D    = 3'h3;
  localparam logic [2:0] REG_E    = 3'h4;
  localparam logic [2:0] REG_H    = 3'h5;
  localparam logic [2:0] REG_L    = 3'h6;
  localparam logic [2:0] REG_NONE = 3'h7;

  // Register pair codes
  localparam logic [1:0] PAIR_BC = 2'h0;
  localparam logic [1:0] PAIR_DE = 2'h1;
  localparam logic [1:0] PAIR_HL = 2'h2;
  localparam logic [1:0] PAIR_SP = 2'h3;

  // Reset values
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [15:0] SP_RST = 16'h0000;

  // Commands written to the control register
  typedef enum logic [3:0] {
    CMD_NOP   = 4'h0, CMD_FETCH = 4'h1, CMD_MOV  = 4'h2, CMD_MVI  = 4'h3,
    CMD_LXI   = 4'h4, CMD_ALUR  = 4'h5, CMD_ALUI = 4'h6, CMD_INR  = 4'h7,
    CMD_DCR   = 4'h8, CMD_JMP   = 4'h9, CMD_JPR  = 4'ha, CMD_RST  = 4'hb,
    CMD_LDA   = 4'hc, CMD_STA   = 4'hd, CMD_LDAX = 4'he, CMD_LD16 = 4'hf
  } cpod_cmd_t;

  // Arithmetic and logic operation codes
  localparam logic [2:0] ALU_ADD = 3'h0;
  localparam logic [2:0] ALU_ADC = 3'h1;
  localparam logic [2:0] ALU_SUB = 3'h2;
  localparam logic [2:0] ALU_SBB = 3'h3;
  localparam logic [2:0] ALU_AND = 3'h4;
  localparam logic [2:0] ALU_XOR = 3'h5;
  localparam logic [2:0] ALU_OR  = 3'h6;
  localparam logic [2:0] ALU_CMP = 3'h7;

  // Memory sequencer states, Gray coded along the read path except the CAPT to ISSUE step
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ISSUE  = 2'b01,
    ST_STROBE = 2'b11,
    ST_CAPT   = 2'b10
  } cpod_state_t;

endpackage
`default_nettype wire

// >>> dv/cpod_core_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module cpod_core_assertions
  import cpod_pkg::*;
(
  // Clock, reset and register bus
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic        hsel_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic        hready_i,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  // Memory bus and hand-over
  input wire logic [15:0] mem_addr_o,
  input wire logic        mem_addr_oe_o,
  input wire logic        mem_rd_o,
  input wire logic        mem_wr_o,
  input wire logic        mem_ctl_oe_o,
  input wire logic        mem_wdata_oe_o,
  input wire logic        dma_hold_i,
  input wire logic        dma_grant_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Accepted bus request
  sequence s_take;
    hsel_i && hready_i && htrans_i[1];
  endsequence
  property p_resp_ok; hresp_o == HRESP_OK; endproperty
  property p_rd_wait;
    s_take ##0 !hwrite_i |=> !hreadyout_o ##1 hreadyout_o;
  endproperty
  property p_wr_nowait; s_take ##0 hwrite_i |=> hreadyout_o; endproperty
  property p_strobe_one;
    mem_rd_o || mem_wr_o |=> !mem_rd_o && !mem_wr_o;
  endproperty
  // Bytes of one sequence sit at rising addresses
  property p_seq_addr;
    mem_rd_o ##3 mem_rd_o |-> mem_addr_o == $past(mem_addr_o, 3) + 16'h1;
  endproperty
  property p_oe_grant;
    mem_addr_oe_o == !dma_grant_o && mem_ctl_oe_o == mem_addr_oe_o;
  endproperty
  property p_quiet;
    dma_grant_o |-> !mem_rd_o && !mem_wr_o && !mem_wdata_oe_o;
  endproperty
  property p_grant_by; dma_hold_i [*4] |-> dma_grant_o; endproperty
  property p_release; (!dma_hold_i) [*4] |-> !dma_grant_o; endproperty
  property p_wdata_oe; mem_wdata_oe_o == mem_wr_o; endproperty
  a_resp_ok:    assert property (p_resp_ok) else $error("bad hresp");
  a_rd_wait:    assert property (p_rd_wait) else $error("read wait");
  a_wr_nowait:  assert property (p_wr_nowait) else $error("write wait");
  a_strobe_one: assert property (p_strobe_one) else $error("long strobe");
  a_seq_addr:   assert property (p_seq_addr) else $error("byte order");
  a_oe_grant:   assert property (p_oe_grant) else $error("oe mismatch");
  a_quiet:      assert property (p_quiet) else $error("strobe granted");
  a_grant_by:   assert property (p_grant_by) else $error("no grant");
  a_release:    assert property (p_release) else $error("no release");
  a_wdata_oe:   assert property (p_wdata_oe) else $error("wdata oe");
  c_rd:    cover property (mem_rd_o ##3 mem_rd_o);
  c_wr:    cover property (mem_wr_o);
  c_grant: cover property ($rose(dma_grant_o));
endmodule
bind cpod_core cpod_core_assertions cpod_core_assertions_i (
  .clk_i(clk_i), .reset_i(reset_i), .hsel_i(hsel_i), .htrans_i(htrans_i),
  .hwrite_i(hwrite_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o), .mem_addr_o(mem_addr_o),
  .mem_addr_oe_o(mem_addr_oe_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
  .mem_ctl_oe_o(mem_ctl_oe_o), .mem_wdata_oe_o(mem_wdata_oe_o),
  .dma_hold_i(dma_hold_i), .dma_grant_o(dma_grant_o));
`default_nettype wire

// >>> dv/cpod_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module cpod_mem_model (
  // Memory side pins
  input wire logic        clk_i,
  input wire logic [15:0] addr_i,
  input wire logic        rd_i,
  input wire logic        wr_i,
  input wire logic        ctl_oe_i,
  input wire logic [7:0]  wdata_i,
  input wire logic        wdata_oe_i,
  output logic     [7:0]  rdata_o
);
  logic [7:0] mem [0:255];   // Aliases every 256 bytes
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i * 7 + 3);
    rdata_o = 8'h00;
  end
  always @(posedge clk_i) begin
    // Released bus toggles so stale data never looks valid
    if (rd_i && ctl_oe_i) rdata_o <= mem[addr_i[7:0]];
    else rdata_o <= ~rdata_o;
    if (wr_i && wdata_oe_i && ctl_oe_i) mem[addr_i[7:0]] <= wdata_i;
  end
endmodule
`default_nettype wire

// >>> dv/cpod_core_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module cpod_core_tb_top;
  import cpod_pkg::*;
  logic clk_i = 0, reset_i = 1, hsel_i = 0, hwrite_i = 0, dma_hold_i = 0;
  logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o, rd;
  logic [1:0]  htrans_i = 0;
  logic [2:0]  hsize_i = SIZE_WORD;
  logic        hreadyout_o, hresp_o, mem_addr_oe_o, mem_rd_o, mem_wr_o;
  logic        mem_ctl_oe_o, mem_wdata_oe_o, dma_grant_o;
  logic [15:0] mem_addr_o, pc;
  logic [7:0]  mem_wdata_o, mem_rdata_i, b2, b3, rg [0:6];
  logic [12:0] ex;
  logic [2:0]  d, s;
  int          error_cnt = 0, tests_run = 0;
  cpod_core cpod_core_i (.clk_i(clk_i), .reset_i(reset_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .mem_addr_o(mem_addr_o), .mem_addr_oe_o(mem_addr_oe_o),
    .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_ctl_oe_o(mem_ctl_oe_o),
    .mem_wdata_o(mem_wdata_o), .mem_wdata_oe_o(mem_wdata_oe_o),
    .mem_rdata_i(mem_rdata_i), .dma_hold_i(dma_hold_i),
    .dma_grant_o(dma_grant_o));
  cpod_mem_model cpod_mem_model_i (.clk_i(clk_i), .addr_i(mem_addr_o),
    .rd_i(mem_rd_o), .wr_i(mem_wr_o), .ctl_oe_i(mem_ctl_oe_o),
    .wdata_i(mem_wdata_o), .wdata_oe_i(mem_wdata_oe_o),
    .rdata_o(mem_rdata_i));
  // Free-running clock
  initial forever #4 clk_i = ~clk_i;
  // Initial memory image, mirrors the partner's preload
  function automatic logic [7:0] m(input logic [15:0] a);
    return a[7:0] * 8'h07 + 8'h03;
  endfunction
  // Expected {sign,zero,half,parity,carry,result}
  function automatic logic [12:0] alu(input logic [2:0] op,
                                      input logic [7:0] a, b,
                                      input logic cy);
    logic [8:0] t;
    logic h, c, bi;
    bi = (op == ALU_ADC || op == ALU_SBB) ? cy : 1'b0;
    c = 1'b0;
    h = 1'b0;
    case (op)
      ALU_ADD, ALU_ADC: begin
        t = {1'b0, a} + {1'b0, b} + bi;
        h = ({1'b0, a[3:0]} + {1'b0, b[3:0]} + bi) > 5'h0f;
        c = t[8];
      end
      ALU_AND: begin
        t = {1'b0, a & b};
        h = a[3] | b[3];
      end
      ALU_XOR: t = {1'b0, a ^ b};
      ALU_OR:  t = {1'b0, a | b};
      default: begin
        // Borrow is the inverted carry of a + ~b + 1
        t = {1'b0, a} + {1'b0, ~b} + !bi;
        h = ({1'b0, a[3:0]} + {1'b0, ~b[3:0]} + !bi) > 5'h0f;
        c = !t[8];
      end
    endcase
    return {t[7], t[7:0] == 8'h00, h, ~^t[7:0], c, t[7:0]};
  endfunction
  // One AHB-Lite single word transfer; read data lands in rd
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge clk_i);
    hsel_i   <= 1'b1;
    htrans_i <= 2'h2;
    hwrite_i <= w;
    haddr_i  <= {24'h0, a};
    @(posedge clk_i);
    while (hreadyout_o !== 1'b1) @(posedge clk_i);
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    @(posedge clk_i);
    while (hreadyout_o !== 1'b1) @(posedge clk_i);
    rd = hrdata_o;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic issue(input logic [3:0] c, input logic [1:0] l,
                       input logic [7:0] x1, x2, x3);
    bus(1'b1, OFS_INSTR, {8'h0, x3, x2, x1});
    bus(1'b1, OFS_CTRL, {26'h0, l, c});
  endtask
  // Poll until the command is done; the watchdog bounds it
  task automatic run(input logic [3:0] c, input logic [1:0] l,
                     input logic [7:0] x1, x2, x3);
    issue(c, l, x1, x2, x3);
    do bus(1'b0, OFS_CTRL, 32'h0); while (rd[STAT_BUSY] !== 1'b0);
  endtask
  task automatic ldregs;
    bus(1'b1, OFS_GPR0, {rg[3], rg[2], rg[1], rg[0]});
    bus(1'b1, OFS_GPR1, {8'h0, rg[6], rg[5], rg[4]});
  endtask
  task automatic ckregs;
    bus(1'b0, OFS_GPR0, 32'h0);
    chk(rd, {rg[3], rg[2], rg[1], rg[0]});
    bus(1'b0, OFS_GPR1, 32'h0);
    chk(rd, {8'h0, rg[6], rg[5], rg[4]});
  endtask
  task automatic rnd;
    for (int k = 0; k < 7; k++) rg[k] = 8'($urandom);
    ldregs;
  endtask
  task automatic tally_and_finish;
    $display("mismatches %0d of %0d comparisons", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Hang guard, far beyond the few thousand cycles needed
  initial begin
    #400000;
    error_cnt++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(32'h8b85));
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    // Flags, counter, stack pointer, registers A to D clear at reset
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, OFS_FLAGS + 8'(4 * i), 32'h0);
      chk(rd, 32'h0);
    end
    // Unmapped place reads zero
    bus(1'b1, 8'h40, 32'hffff);
    bus(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    // Every operation, from register and immediate, corner first
    for (int i = 0; i < 24; i++) begin
      rnd;
      if (i < 8) begin
        rg[0] = 8'h0f;
        rg[1] = 8'h01;
        ldregs;
      end
      b2 = 8'($urandom);
      bus(1'b1, OFS_FLAGS, {27'h0, b2[4:0]});
      run(i[3] ? CMD_ALUI : CMD_ALUR, 2'h0, {2'b10, i[2:0], REG_B},
          rg[1], 8'h0);
      ex = alu(i[2:0], rg[0], rg[1], b2[FLG_CARRY]);
      bus(1'b0, OFS_FLAGS, 32'h0);
      chk(rd, {27'h0, ex[12:8]});
      if (i[2:0] != ALU_CMP) rg[0] = ex[7:0];
      ckregs;
    end
    run(CMD_INR, 2'h0, 8'h04, 8'h0, 8'h0);
    ex = alu(ALU_ADD, rg[0], 8'h01, 1'b0);
    bus(1'b0, OFS_FLAGS, 32'h0);
    chk(rd[4:1], ex[12:9]);
    // Register moves, random fields
    for (int i = 0; i < 8; i++) begin
      rnd;
      d = 3'($urandom_range(6));
      s = 3'($urandom_range(6));
      run(CMD_MOV, 2'h0, {2'b01, d, s}, 8'h0, 8'h0);
      rg[d] = rg[s];
      ckregs;
    end
    // Every pair code
    for (int p = 0; p < 4; p++) begin
      b2 = 8'($urandom);
      b3 = 8'($urandom);
      run(CMD_LXI, 2'h0, {2'b00, 2'(p), 4'h1}, b2, b3);
      if (p < 3) begin
        rg[1 + 2 * p] = b3;
        rg[2 + 2 * p] = b2;
      end
      ckregs;
      bus(1'b0, OFS_SP, 32'h0);
      if (p == 3) chk(rd, {16'h0, b3, b2});
    end
    // Direct and register branches
    run(CMD_JMP, 2'h0, 8'hc3, b2, 8'h5a);
    bus(1'b0, OFS_PC, 32'h0);
    chk(rd, {16'h0, 8'h5a, b2});
    run(CMD_JPR, 2'h0, {2'b11, PAIR_HL, 4'h9}, 8'h0, 8'h0);
    bus(1'b0, OFS_PC, 32'h0);
    chk(rd, {16'h0, rg[5], rg[6]});
    for (int n = 0; n < 8; n++) begin
      run(CMD_RST, 2'h0, {2'b11, 3'(n), 3'h7}, 8'h0, 8'h0);
      bus(1'b0, OFS_PC, 32'h0);
      chk(rd, 32'(8 * n));
    end
    // Fetch one to three bytes
    for (int l = 1; l < 4; l++) begin
      pc = 16'($urandom);
      bus(1'b1, OFS_PC, {16'h0, pc});
      run(CMD_FETCH, 2'(l), 8'h0, 8'h0, 8'h0);
      bus(1'b0, OFS_INSTR, 32'h0);
      chk(rd & ~(32'hffffffff << (8 * l)),
          {8'h0, m(pc + 16'h2), m(pc + 16'h1), m(pc)}
          & ~(32'hffffffff << (8 * l)));
      bus(1'b0, OFS_PC, 32'h0);
      chk(rd, {16'h0, pc + 16'(l)});
    end
    // Direct, indirect and two-byte loads
    b2 = 8'($urandom);
    b3 = 8'($urandom);
    run(CMD_LDA, 2'h0, 8'h3a, b2, b3);
    rg[0] = m({b3, b2});
    bus(1'b0, OFS_EADDR, 32'h0);
    chk(rd, {16'h0, b3, b2});
    run(CMD_LDAX, 2'h0, {2'b00, PAIR_BC, 4'ha}, 8'h0, 8'h0);
    rg[0] = m({rg[1], rg[2]});
    ckregs;
    run(CMD_LD16, 2'h0, 8'h2a, b3, b2);
    rg[6] = m({b2, b3});
    rg[5] = m({b2, b3} + 16'h1);
    ckregs;
    // Bus hand-over holds a pending load
    dma_hold_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk({30'h0, mem_addr_oe_o, dma_grant_o}, 32'h1);
    issue(CMD_LDA, 2'h0, 8'h3a, b3, b2);
    repeat (20) @(posedge clk_i);
    bus(1'b0, OFS_CTRL, 32'h0);
    chk(rd[1:0], 2'h3);
    dma_hold_i <= 1'b0;
    do bus(1'b0, OFS_CTRL, 32'h0); while (rd[STAT_BUSY] !== 1'b0);
    rg[0] = m({b2, b3});
    ckregs;
    // Store reaches the memory
    run(CMD_STA, 2'h0, 8'h32, b2, b3);
    chk({24'h0, cpod_mem_model_i.mem[b2]}, {24'h0, rg[0]});
    tally_and_finish;
  end
endmodule
`default_nettype wire
